// ---- logic/cmbx_regs.vh ----
`ifndef CMBX_REGS_VH
`define CMBX_REGS_VH

// ==========================================================
// Register map, byte addresses
`define CMBX_ADDR_W        12
`define CMBX_OFF_TIMER     12'h000
`define CMBX_OFF_ABORT     12'h004
`define CMBX_OFF_XFER      12'h008
`define CMBX_OFF_PEND      12'h00c
`define CMBX_CFG_BASE      12'h100
`define CMBX_MSR_BASE      12'h180
`define CMBX_REGION_MASK   12'hfc0

// ==========================================================
// Field layout
`define CMBX_TIMER_W       16
`define CMBX_TYPE_LSB      0
`define CMBX_TYPE_W        3
`define CMBX_PRIO_LSB      16
`define CMBX_PRIO_W        4
`define CMBX_MSR_RDY_BIT   23
`define CMBX_MSR_ABT_BIT   22
`define CMBX_MSR_ARM_BIT   1
`define CMBX_MSR_PEND_BIT  0
`define CMBX_IDX_W         4

// ==========================================================
// Mailbox object types
`define CMBX_T_OFF         3'h0
`define CMBX_T_RX          3'h1
`define CMBX_T_RXOVR       3'h2
`define CMBX_T_TX          3'h3
`define CMBX_T_CONS        3'h4
`define CMBX_T_PROD        3'h5

// ==========================================================
// Reset values
`define CMBX_TIMER_RST     16'h0000
`define CMBX_PRIO_RST      4'h0

`endif

// ---- logic/cmbx_arb.v ----
`timescale 1ns/1ps
`include "cmbx_regs.vh"

// ==========================================================
// Transmit arbiter: lowest priority value wins, ties to lowest index
module cmbx_arb #(
    parameter N = 16
) (
    input  wire [N-1:0]                req,
    input  wire [N*`CMBX_PRIO_W-1:0]   prio,
    output reg                         any,
    output reg  [`CMBX_IDX_W-1:0]      idx
);
    integer                 i;
    reg [`CMBX_PRIO_W-1:0]  best;

    always @*
    begin
        any  = 1'b0;
        idx  = {`CMBX_IDX_W{1'b0}};
        best = {`CMBX_PRIO_W{1'b1}};
        // priority then index
        // Strict compare keeps the first (lowest) index on a tie
        for (i = 0; i < N; i = i + 1)
        begin
            if (req[i] && (!any || prio[i*`CMBX_PRIO_W +: `CMBX_PRIO_W] < best))
            begin
                any  = 1'b1;
                idx  = i[`CMBX_IDX_W-1:0];
                best = prio[i*`CMBX_PRIO_W +: `CMBX_PRIO_W];
            end
        end
    end
endmodule

// ---- logic/cmbx_top.v ----
`timescale 1ns/1ps
`include "cmbx_regs.vh"

module cmbx_top #(
    parameter N = 16
) (
    input  wire                      clock,
    input  wire                      rstn,
    // APB slave
    input  wire                      psel,
    input  wire                      penable,
    input  wire                      pwrite,
    input  wire [`CMBX_ADDR_W-1:0]   paddr,
    input  wire [31:0]               pwdata,
    output wire                      pready,
    output wire                      pslverr,
    output reg  [31:0]               prdata,
    // Timer tick from bit timing logic
    input  wire                      timer_tick,
    // Offer to the protocol engine
    output reg                       tx_valid,
    input  wire                      tx_ready,
    output reg  [`CMBX_IDX_W-1:0]    tx_mb,
    output reg                       tx_remote,
    input  wire                      tx_done,
    // Received frame from the protocol engine
    input  wire                      rx_valid,
    input  wire [`CMBX_IDX_W-1:0]    rx_mb,
    input  wire                      rx_remote,
    output wire                      rx_accept
);

    // ==========================================================
    // State
    reg [`CMBX_TIMER_W-1:0]          timer_q;
    reg [N*`CMBX_TYPE_W-1:0]         type_q;
    reg [N*`CMBX_PRIO_W-1:0]         prio_q;
    reg [N-1:0]                      pend_q;
    reg [N-1:0]                      pend_d;
    reg [N-1:0]                      armed_q;
    reg [N-1:0]                      armed_d;
    reg [N-1:0]                      rdy_q;
    reg [N-1:0]                      rdy_d;
    reg [N-1:0]                      abt_q;
    reg [N-1:0]                      abt_d;
    reg                              inflight_q;
    reg                              inflight_d;
    reg [`CMBX_IDX_W-1:0]            inflight_mb_q;
    wire                             arb_any;
    wire [`CMBX_IDX_W-1:0]           arb_idx;
    integer                          i;
    reg [`CMBX_TYPE_W-1:0]           t;

    // ==========================================================
    // Address decode
    function is_cfg;
        input [`CMBX_ADDR_W-1:0] a;
        begin
            is_cfg = ((a & `CMBX_REGION_MASK) == `CMBX_CFG_BASE) && (a[1:0] == 2'b00);
        end
    endfunction

    function is_msr;
        input [`CMBX_ADDR_W-1:0] a;
        begin
            is_msr = ((a & `CMBX_REGION_MASK) == `CMBX_MSR_BASE) && (a[1:0] == 2'b00);
        end
    endfunction

    function mapped;
        input [`CMBX_ADDR_W-1:0] a;
        begin
            mapped = (a == `CMBX_OFF_TIMER) || (a == `CMBX_OFF_ABORT) ||
                     (a == `CMBX_OFF_XFER) || (a == `CMBX_OFF_PEND) ||
                     is_cfg(a) || is_msr(a);
        end
    endfunction

    wire [`CMBX_IDX_W-1:0] sel_mb    = paddr[`CMBX_IDX_W+1:2];
    wire                   setup     = psel && !penable;
    wire                   wr_access = psel && penable && pwrite && mapped(paddr);
    wire                   abort_wr  = wr_access && (paddr == `CMBX_OFF_ABORT);
    wire                   xfer_wr   = wr_access && (paddr == `CMBX_OFF_XFER);
    wire                   cfg_wr    = wr_access && is_cfg(paddr);
    wire                   accept    = tx_valid && tx_ready;

    // Zero wait states; read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);

    // ==========================================================
    // Read mux
    function [31:0] rd_word;
        input [`CMBX_ADDR_W-1:0] a;
        input [`CMBX_IDX_W-1:0]  m;
        begin
            rd_word = 32'h0000_0000;
            if (a == `CMBX_OFF_TIMER)
                rd_word[`CMBX_TIMER_W-1:0] = timer_q;
            else if (a == `CMBX_OFF_PEND)
                rd_word[N-1:0] = pend_q;
            else if (is_cfg(a))
            begin
                rd_word[`CMBX_TYPE_LSB +: `CMBX_TYPE_W] = type_q[m*`CMBX_TYPE_W +: `CMBX_TYPE_W];
                rd_word[`CMBX_PRIO_LSB +: `CMBX_PRIO_W] = prio_q[m*`CMBX_PRIO_W +: `CMBX_PRIO_W];
            end
            else if (is_msr(a))
            begin
                rd_word[`CMBX_MSR_RDY_BIT]  = rdy_q[m];
                rd_word[`CMBX_MSR_ABT_BIT]  = abt_q[m];
                rd_word[`CMBX_MSR_ARM_BIT]  = armed_q[m];
                rd_word[`CMBX_MSR_PEND_BIT] = pend_q[m] || (inflight_q && inflight_mb_q == m);
            end
        end
    endfunction

    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata <= rd_word(paddr, sel_mb);
    end

    // ==========================================================
    // Free-running timer
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            timer_q <= `CMBX_TIMER_RST;
        else if (timer_tick)
            timer_q <= timer_q + 16'h0001;
    end

    // ==========================================================
    // Mailbox configuration
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            type_q <= {N*`CMBX_TYPE_W{1'b0}};
            prio_q <= {N{`CMBX_PRIO_RST}};
        end
        else if (cfg_wr)
        begin
            type_q[sel_mb*`CMBX_TYPE_W +: `CMBX_TYPE_W] <= pwdata[`CMBX_TYPE_LSB +: `CMBX_TYPE_W];
            prio_q[sel_mb*`CMBX_PRIO_W +: `CMBX_PRIO_W] <= pwdata[`CMBX_PRIO_LSB +: `CMBX_PRIO_W];
        end
    end

    // ==========================================================
    // Per-mailbox commands and events
    // Clears are applied first so a same-cycle event still sets its flag
    always @*
    begin
        pend_d  = pend_q;
        armed_d = armed_q;
        rdy_d   = rdy_q;
        abt_d   = abt_q;
        t       = `CMBX_T_OFF;
        for (i = 0; i < N; i = i + 1)
        begin
            t = type_q[i*`CMBX_TYPE_W +: `CMBX_TYPE_W];
            if (xfer_wr && pwdata[i])
            begin
                rdy_d[i] = 1'b0;
                abt_d[i] = 1'b0;
                case (t)
                    `CMBX_T_RX, `CMBX_T_RXOVR: armed_d[i] = 1'b1;
                    `CMBX_T_TX:                pend_d[i]  = 1'b1;
                    `CMBX_T_CONS:
                    begin
                        pend_d[i]  = 1'b1;
                        armed_d[i] = 1'b0;
                    end
                    `CMBX_T_PROD:              armed_d[i] = 1'b1;
                    default:                   armed_d[i] = armed_q[i];
                endcase
            end
            if (abort_wr && pwdata[i])
            begin
                case (t)
                    `CMBX_T_TX:
                        if (pend_q[i])
                        begin
                            pend_d[i] = 1'b0;
                            abt_d[i]  = 1'b1;
                        end
                    `CMBX_T_CONS:
                        if (pend_q[i] || armed_q[i])
                        begin
                            pend_d[i]  = 1'b0;
                            armed_d[i] = 1'b0;
                            abt_d[i]   = 1'b1;
                        end
                    `CMBX_T_PROD:
                        if (pend_q[i] || armed_q[i])
                        begin
                            pend_d[i]  = 1'b0;
                            armed_d[i] = 1'b0;
                            abt_d[i]   = 1'b1;
                        end
                    default:      abt_d[i] = abt_d[i];
                endcase
            end
            if (accept && tx_mb == i[`CMBX_IDX_W-1:0])
            begin
                pend_d[i] = 1'b0;
                if (abt_d[i] && !abt_q[i])
                    abt_d[i] = 1'b0;
            end
            if (tx_done && inflight_q && inflight_mb_q == i[`CMBX_IDX_W-1:0])
            begin
                if (t == `CMBX_T_CONS)
                    armed_d[i] = 1'b1;
                else
                    rdy_d[i] = 1'b1;
                if (t == `CMBX_T_PROD)
                    armed_d[i] = 1'b0;
            end
            if (rx_valid && rx_mb == i[`CMBX_IDX_W-1:0] && armed_q[i])
            begin
                case (t)
                    `CMBX_T_RX, `CMBX_T_RXOVR, `CMBX_T_CONS:
                        if (!rx_remote)
                        begin
                            rdy_d[i]   = 1'b1;
                            armed_d[i] = armed_d[i] && (t == `CMBX_T_RXOVR);
                        end
                    `CMBX_T_PROD:
                        if (rx_remote)
                        begin
                            pend_d[i]  = 1'b1;
                            armed_d[i] = 1'b0;
                        end
                    default: rdy_d[i] = rdy_d[i];
                endcase
            end
        end
    end

    assign rx_accept = rx_valid && armed_q[rx_mb] &&
                       ((type_q[rx_mb*`CMBX_TYPE_W +: `CMBX_TYPE_W] == `CMBX_T_PROD) == rx_remote);

    always @*
    begin
        inflight_d = inflight_q;
        if (accept)
            inflight_d = 1'b1;
        else if (tx_done)
            inflight_d = 1'b0;
    end

    // ==========================================================
    // Arbitration on next-state requests, so an aborted mailbox is never offered
    cmbx_arb #(
        .N    (N)
    ) u_arb (
        .req  (pend_d),
        .prio (prio_q),
        .any  (arb_any),
        .idx  (arb_idx)
    );

    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            pend_q        <= {N{1'b0}};
            armed_q       <= {N{1'b0}};
            rdy_q         <= {N{1'b0}};
            abt_q         <= {N{1'b0}};
            inflight_q    <= 1'b0;
            inflight_mb_q <= {`CMBX_IDX_W{1'b0}};
            tx_valid      <= 1'b0;
            tx_mb         <= {`CMBX_IDX_W{1'b0}};
            tx_remote     <= 1'b0;
        end
        else
        begin
            pend_q     <= pend_d;
            armed_q    <= armed_d;
            rdy_q      <= rdy_d;
            abt_q      <= abt_d;
            inflight_q <= inflight_d;
            if (accept)
                inflight_mb_q <= tx_mb;
            tx_valid <= arb_any && !inflight_d;
            if (arb_any && !inflight_d)
            begin
                tx_mb     <= arb_idx;
                tx_remote <= (type_q[arb_idx*`CMBX_TYPE_W +: `CMBX_TYPE_W] == `CMBX_T_CONS);
            end
        end
    end

endmodule

// ---- verification/cmbx_assertions.sv ----
`timescale 1ns/1ps
`include "cmbx_regs.vh"
// ==========================================
// Port checker
module cmbx_chk (
    input wire        clock,
    input wire        rstn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire [31:0] prdata,
    input wire        tx_valid,
    input wire        tx_ready,
    input wire [3:0]  tx_mb,
    input wire        tx_done,
    input wire        rx_valid
);
    reg fly_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_rd(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence s_wr(a);
        psel && penable && pwrite && paddr == a;
    endsequence
    // Frame in flight from hand-over to done
    always @(posedge clock or negedge rstn)
        if (!rstn)
            fly_q <= 1'b0;
        else if (tx_done)
            fly_q <= 1'b0;
        else if (tx_valid && tx_ready)
            fly_q <= 1'b1;
    chk_timer_upper: assert property (
        s_rd(`CMBX_OFF_TIMER) |=> prdata[31:16] == 16'h0000) else $error("timer upper set");
    chk_prdata_hold: assert property (
        !(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("read data moved");
    chk_ready_access: assert property (psel && penable |-> pready) else $error("no ready");
    chk_err_phase: assert property (pslverr |-> psel && penable) else $error("stray error");
    chk_offer_hold: assert property (
        tx_valid && !tx_ready && !(psel && penable && pwrite && paddr == `CMBX_OFF_ABORT)
        |=> tx_valid) else $error("offer withdrawn");
    chk_abort_drop: assert property (
        s_wr(`CMBX_OFF_ABORT) ##0 (tx_valid && !tx_ready && pwdata[tx_mb])
        |=> !tx_valid || tx_mb != $past(tx_mb)) else $error("aborted offer kept");
    chk_no_offer_fly: assert property (
        fly_q |-> !tx_valid) else $error("offer while in flight");
    chk_zero_write: assert property (
        s_wr(`CMBX_OFF_XFER) ##0 (pwdata == 32'h0 && !tx_valid && !fly_q && !rx_valid
        && !tx_done && !$past(rx_valid)) |=> !tx_valid) else $error("zero write acted");
endmodule
bind cmbx_top cmbx_chk u_chk (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_mb(tx_mb),
    .tx_done(tx_done), .rx_valid(rx_valid));

// ---- verification/cmbx_engine.sv ----
`timescale 1ns/1ps
// ==========================================
// Protocol engine stand-in; stall sets how slow it takes offers
module cmbx_engine #(
    parameter FRAME = 8
) (
    input  wire       clock,
    input  wire       rstn,
    input  wire       tx_valid,
    input  wire [7:0] stall,
    output reg        tx_ready,
    output reg        tx_done
);
    integer cnt;
    reg     busy;
    always @(posedge clock or negedge rstn)
        if (!rstn)
        begin
            {tx_ready, tx_done, busy} <= 3'b000;
            cnt <= 0;
        end
        else
        begin
            tx_done <= 1'b0;
            if (busy)
            begin
                cnt <= cnt - 1;
                // One done pulse per frame taken, never while idle
                if (cnt == 1)
                    {busy, tx_done} <= 2'b01;
            end
            else if (tx_valid && tx_ready)
            begin
                {tx_ready, busy} <= 2'b01;
                cnt <= FRAME;
            end
            else if (tx_valid)
            begin
                tx_ready <= (cnt >= stall);
                cnt <= cnt + 1;
            end
            else
            begin
                tx_ready <= 1'b0;
                cnt <= 0;
            end
        end
endmodule

// ---- verification/tb_can_mailbox_command_logic.sv ----
`timescale 1ns/1ps
`include "cmbx_regs.vh"
module tb_can_mailbox_command_logic;
    reg         clock, rstn, psel, penable, pwrite, timer_tick, rx_valid, rx_remote, err;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, seed, rd;
    reg  [3:0]  rx_mb, pr[16];
    reg  [7:0]  stall;
    reg  [4:0]  got[$], eq[$];
    wire        pready, pslverr, tx_valid, tx_ready, tx_remote, tx_done, rx_accept;
    wire [31:0] prdata;
    wire [3:0]  tx_mb;
    integer     bad_count, checked, i, j, n;
    cmbx_top dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .timer_tick(timer_tick), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_mb(tx_mb),
        .tx_remote(tx_remote), .tx_done(tx_done), .rx_valid(rx_valid), .rx_mb(rx_mb),
        .rx_remote(rx_remote), .rx_accept(rx_accept));
    cmbx_engine eng (.clock(clock), .rstn(rstn), .tx_valid(tx_valid), .stall(stall),
        .tx_ready(tx_ready), .tx_done(tx_done));
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ==========================================
    // Helpers
    always @(posedge clock)
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            got.push_back({tx_remote, tx_mb});
    function [31:0] xs(input [31:0] s);
    begin
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    end
    endfunction
    task cmp(input [31:0] g, input [31:0] e);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    // Request held until ready is seen at an edge
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    end
    endtask
    task cfg(input [3:0] m, input [2:0] t, input [3:0] p);
        apb(1'b1, `CMBX_CFG_BASE + {6'h00, m, 2'b00}, {12'h000, p, 13'h0000, t});
    endtask
    task rx(input [3:0] m, input r, input e);
    begin
        @(posedge clock);
        {rx_valid, rx_mb, rx_remote} <= {1'b1, m, r};
        @(negedge clock);
        cmp(rx_accept, e);
        @(posedge clock);
        rx_valid <= 1'b0;
    end
    endtask
    // Waits for k frames, then a quiet span to catch extra ones
    task drain(input integer k);
    begin
        while (got.size() < k)
            @(posedge clock);
        repeat (40) @(posedge clock);
        cmp(got.size(), eq.size());
        for (j = 0; j < eq.size(); j = j + 1)
            cmp(got[j], eq[j]);
        got.delete();
        eq.delete();
    end
    endtask
    task end_of_test;
    begin
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count = bad_count + 1;
        end_of_test;
    end
    // ==========================================
    // Tests
    initial
    begin
        {rstn, psel, penable, pwrite, timer_tick, rx_valid, rx_remote} = 7'h00;
        {paddr, pwdata, rx_mb, stall} = 56'h0;
        {bad_count, checked, n} = 0;
        seed = 32'h99fcaa5b;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        apb(1'b0, `CMBX_OFF_TIMER, 32'h0);
        cmp(rd, 32'h0);
        repeat (40)
        begin
            @(posedge clock);
            seed = xs(seed);
            timer_tick <= seed[0];
            n = n + seed[0];
        end
        @(posedge clock);
        timer_tick <= 1'b0;
        apb(1'b0, `CMBX_OFF_TIMER, 32'h0);
        cmp(rd, n);
        apb(1'b0, 12'h0f0, 32'h0);
        cmp(err, 32'h1);
        cmp(rd, 32'h0);
        $display("timer test done");
        // Ties forced between first and last mailbox
        for (i = 0; i < 16; i = i + 1)
        begin
            seed = xs(seed);
            pr[i] = (i == 15) ? pr[0] : seed[1:0];
            cfg(i, (i == 2) ? `CMBX_T_RX : (i == 4) ? `CMBX_T_CONS : `CMBX_T_TX, pr[i]);
        end
        for (j = 0; j < 4; j = j + 1)
            for (i = 0; i < 16; i = i + 1)
                if (i != 2 && pr[i] == j)
                    eq.push_back({i == 4, i[3:0]});
        stall <= seed[10:8];
        apb(1'b1, `CMBX_OFF_XFER, 32'hffff);
        drain(15);
        $display("priority test done");
        stall <= 8'd200;
        apb(1'b1, `CMBX_OFF_XFER, 32'h0);
        apb(1'b1, `CMBX_OFF_XFER, 32'h150);
        apb(1'b1, `CMBX_OFF_ABORT, 32'h050);
        stall <= 8'd0;
        eq.push_back(5'h08);
        drain(1);
        apb(1'b0, 12'h198, 32'h0);
        cmp(rd & 32'hc00000, 32'h400000);
        apb(1'b0, 12'h190, 32'h0);
        cmp(rd & 32'hc00000, 32'h400000);
        apb(1'b0, 12'h1a0, 32'h0);
        cmp(rd & 32'hc00000, 32'h800000);
        stall <= 8'd200;
        apb(1'b1, `CMBX_OFF_XFER, 32'h140);
        apb(1'b0, `CMBX_OFF_PEND, 32'h0);
        cmp(rd, 32'h140);
        for (i = 0; i < 2; i = i + 1)
        begin
            apb(1'b0, i ? 12'h1a0 : 12'h198, 32'h0);
            cmp(rd & 32'hc00000, 32'h0);
        end
        apb(1'b1, `CMBX_OFF_ABORT, 32'h140);
        stall <= 8'd0;
        apb(1'b0, `CMBX_OFF_PEND, 32'h0);
        cmp(rd, 32'h0);
        $display("abort test done");
        cfg(10, `CMBX_T_RX, 0);
        cfg(11, `CMBX_T_RXOVR, 0);
        cfg(12, `CMBX_T_PROD, 0);
        // Disabled mailbox 9 must not queue anything, only lose its ready and abort flags
        cfg(9, `CMBX_T_OFF, 0);
        apb(1'b1, `CMBX_OFF_XFER, 32'h1e00);
        apb(1'b0, 12'h1a4, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b0, 12'h1b0, 32'h0);
        cmp(rd, 32'h2);
        apb(1'b0, 12'h130, 32'h0);
        cmp(rd, 32'h5);
        rx(10, 1'b0, 1'b1);
        rx(10, 1'b0, 1'b0);
        rx(11, 1'b0, 1'b1);
        rx(11, 1'b0, 1'b1);
        rx(12, 1'b1, 1'b1);
        eq.push_back(5'h0c);
        drain(1);
        apb(1'b1, `CMBX_OFF_XFER, 32'h1000);
        apb(1'b1, `CMBX_OFF_ABORT, 32'h1000);
        rx(12, 1'b1, 1'b0);
        drain(0);
        $display("receive test done");
        end_of_test;
    end
endmodule
